/* hw/rit_edge.sv */
// Selectable edge detector for the top port pin
`timescale 1ns/10ps
module rit_edge
	import rit_pkg::*;
(
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire logic pin_i,
	input wire logic rising_i,
	output logic edge_o
);

	logic prev_ff;
	logic primed_ff;
	logic edge_ff;
	logic seen;

	assign seen = rising_i ? (pin_i && !prev_ff) : (!pin_i && prev_ff);

	// First sample after reset only primes, so no false edge
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			prev_ff <= 1'b0;
			primed_ff <= 1'b0;
			edge_ff <= 1'b0;
		end else begin
			prev_ff <= pin_i;
			primed_ff <= 1'b1;
			edge_ff <= primed_ff && seen;
		end
	end

	assign edge_o = edge_ff;

	edge_det_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		(primed_ff && pin_i != prev_ff && pin_i == rising_i) |=> edge_ff)
		else $error("selected edge not detected");

endmodule

/* hw/rit_pkg.sv */
// Constants, address map and decode helpers for the RAM/IO/timer block
package rit_pkg;

	localparam int ADDR_W = 12;
	localparam int RAM_DEPTH = 128;
	localparam int RAM_AW = 7;
	localparam int MAX_TIMEOUT_T = 262144;

	// Byte addresses; every register is one aligned 32-bit word
	localparam logic [11:0] RAM_BASE = 12'h000;
	localparam logic [11:0] IO_BASE = 12'h200;
	localparam logic [11:0] STS_ADDR = 12'h300;
	localparam logic [11:0] MSK_ADDR = 12'h304;
	localparam logic [11:0] EDGE_ADDR = 12'h308;

	// Word index inside the IO window, bits [5:2] of the byte address
	localparam logic [1:0] PORT_PA_DATA = 2'h0;
	localparam logic [1:0] PORT_PA_DIR = 2'h1;
	localparam logic [1:0] PORT_PB_DATA = 2'h2;
	localparam logic [1:0] PORT_PB_DIR = 2'h3;
	localparam int IDX_FLAG_BIT = 0;
	localparam int IDX_TMR_BIT = 2;
	localparam int IDX_IRQ_EN_BIT = 3;

	localparam int FLAG_TMR_BIT = 7;
	localparam int FLAG_EDGE_BIT = 6;
	localparam int STS_TMR = 0;
	localparam int STS_EDGE = 1;
	localparam int EDGE_RISE_BIT = 0;
	localparam int EDGE_EN_BIT = 1;

	localparam logic [7:0] PORT_RST = 8'h00;
	localparam logic [1:0] IRQ_RST = 2'h0;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Prescaler reload values for divide by 1, 8, 64 and 1024
	localparam logic [9:0] PRE_DIV1 = 10'h000;
	localparam logic [9:0] PRE_DIV8 = 10'h007;
	localparam logic [9:0] PRE_DIV64 = 10'h03f;
	localparam logic [9:0] PRE_DIV1024 = 10'h3ff;

	typedef enum logic [4:0] {
		SEL_NONE = 5'h01,
		SEL_RAM = 5'h02,
		SEL_PORT = 5'h04,
		SEL_TMR = 5'h08,
		SEL_OWN = 5'h10
	} rit_sel_type;

	function automatic rit_sel_type rit_decode(input logic [11:0] a);
		rit_sel_type s;
		s = SEL_NONE;
		if (a[11:9] == RAM_BASE[11:9]) begin
			s = SEL_RAM;
		end else if (a[11:6] == IO_BASE[11:6]) begin
			s = a[IDX_TMR_BIT + 2] ? SEL_TMR : SEL_PORT;
		end else if (a == STS_ADDR || a == MSK_ADDR || a == EDGE_ADDR) begin
			s = SEL_OWN;
		end
		return s;
	endfunction

	function automatic logic [9:0] rit_pre_load(input logic [1:0] sel);
		logic [9:0] v;
		v = PRE_DIV1;
		unique case (sel)
			2'h0: v = PRE_DIV1;
			2'h1: v = PRE_DIV8;
			2'h2: v = PRE_DIV64;
			2'h3: v = PRE_DIV1024;
		endcase
		return v;
	endfunction

endpackage

/* hw/rit_timer.sv */
// Interval timer with prescaler, wrap-around count and expiry flag
`timescale 1ns/10ps
module rit_timer
	import rit_pkg::*;
(
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire logic load_i,
	input wire logic [7:0] load_val_i,
	input wire logic [1:0] pre_sel_i,
	input wire logic access_i,
	output logic [7:0] count_o,
	output logic flag_o,
	output logic expire_o
);

	logic [7:0] cnt_ff;
	logic [9:0] pre_ff;
	logic [9:0] div_ff;
	logic post_ff;
	logic flag_ff;
	logic expire_ff;
	logic hit;

	// Expiry one clock after the count reaches zero
	assign hit = !post_ff && cnt_ff == 8'h00 && !load_i;

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			cnt_ff <= 8'h00;
			pre_ff <= PRE_DIV1;
			div_ff <= PRE_DIV1;
			post_ff <= 1'b1;
		end else if (load_i) begin
			cnt_ff <= load_val_i;
			pre_ff <= rit_pre_load(pre_sel_i);
			div_ff <= rit_pre_load(pre_sel_i);
			post_ff <= 1'b0;
		end else if (hit) begin
			cnt_ff <= 8'hff;
			post_ff <= 1'b1;
		end else if (post_ff) begin
			// After expiry the count tells elapsed clocks
			cnt_ff <= cnt_ff - 8'h01;
		end else if (pre_ff == 10'h000) begin
			cnt_ff <= cnt_ff - 8'h01;
			pre_ff <= div_ff;
		end else begin
			pre_ff <= pre_ff - 10'h001;
		end
	end

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			flag_ff <= 1'b0;
			expire_ff <= 1'b0;
		end else begin
			expire_ff <= hit;
			// Access in the expiry cycle does not clear the flag
			if (hit) begin
				flag_ff <= 1'b1;
			end else if (access_i) begin
				flag_ff <= 1'b0;
			end
		end
	end

	assign count_o = cnt_ff;
	assign flag_o = flag_ff;
	assign expire_o = expire_ff;

	tmr_wrap_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		hit |=> (expire_ff && flag_ff && cnt_ff == 8'hff && post_ff))
		else $error("timer did not wrap and flag on expiry");

	min_timeout_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		(load_i && load_val_i == 8'h00) ##1 !load_i |=> expire_ff)
		else $error("zero load did not expire after one clock");

	pre_eight_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		(load_i && pre_sel_i == 2'h1 && load_val_i == 8'h01) ##1
		(!load_i && !expire_ff)[*8] ##1 !load_i |=> expire_ff)
		else $error("divide by eight timeout not nine clocks");

	flag_clear_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		(access_i && !hit) |=> !flag_ff)
		else $error("timer access did not clear flag");

endmodule

/* hw/rit_top.sv */
// RAM, two I/O ports, interval timer and edge interrupt on AXI4-Lite
`timescale 1ns/10ps
// Function
// - Reset zeroes direction and output latches
// - All port pins are inputs after reset
// - No read data driven during reset
// - Reset disables all interrupt generation
// - Timeouts span one to 261121 clocks
// - 128 bytes of read/write memory
// - Two independent 8-bit bidirectional ports
// - Readable writable direction register per port
// - Selectable edge on top pin raises interrupt
// - Data moves as 8-bit bytes
// - Direction bit one drives latch, zero inputs
// - Timer write picks prescale 1/8/64/1024
// - Expiry sets flag bit7, access clears
// - Timer access samples interrupt enable line
module rit_top
	import rit_pkg::*;
(
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire logic [11:0] s_axi_awaddr_i,
	input wire logic s_axi_awvalid_i,
	output logic s_axi_awready_o,
	input wire logic [31:0] s_axi_wdata_i,
	input wire logic [3:0] s_axi_wstrb_i,
	input wire logic s_axi_wvalid_i,
	output logic s_axi_wready_o,
	output logic [1:0] s_axi_bresp_o,
	output logic s_axi_bvalid_o,
	input wire logic s_axi_bready_i,
	input wire logic [11:0] s_axi_araddr_i,
	input wire logic s_axi_arvalid_i,
	output logic s_axi_arready_o,
	output logic [31:0] s_axi_rdata_o,
	output logic [1:0] s_axi_rresp_o,
	output logic s_axi_rvalid_o,
	input wire logic s_axi_rready_i,
	input wire logic [7:0] port_a_i,
	output logic [7:0] port_a_o,
	output logic [7:0] port_a_oe_o,
	input wire logic [7:0] port_b_i,
	output logic [7:0] port_b_o,
	output logic [7:0] port_b_oe_o,
	output logic irq_o
);

	logic awready_ff;
	logic aw_held_ff;
	logic [11:0] awaddr_ff;
	logic wready_ff;
	logic w_held_ff;
	logic [7:0] wdata_ff;
	logic wstrb0_ff;
	logic bvalid_ff;
	logic [1:0] bresp_ff;
	logic arready_ff;
	logic rvalid_ff;
	logic [1:0] rresp_ff;
	logic [7:0] rdata_ff;
	logic [7:0] nxt_rdata;
	logic [1:0] nxt_rresp;

	logic [7:0] port_a_direction_ff;
	logic [7:0] port_b_direction_ff;
	logic [7:0] port_a_output_latch_ff;
	logic [7:0] port_b_output_latch_ff;
	logic [7:0] ram_mem [RAM_DEPTH];

	logic timer_irq_enable_line_ff;
	logic [1:0] edge_ctl_ff;
	logic edge_flag_ff;
	logic [1:0] sts_ff;
	logic [1:0] msk_ff;
	logic irq_ff;

	logic aw_take;
	logic w_take;
	logic ar_take;
	logic do_wr;
	logic wr_en;
	rit_sel_type wr_sel;
	rit_sel_type rd_sel;
	logic [3:0] wr_idx;
	logic [3:0] rd_idx;
	logic [RAM_AW-1:0] wr_ram_idx;
	logic [RAM_AW-1:0] rd_ram_idx;
	logic rd_irq_line;
	logic wr_tmr;
	logic rd_tmr;
	logic rd_flag;
	logic [7:0] port_b_view;
	logic port_a_top_pin;
	logic [7:0] tmr_count;
	logic tmr_flag;
	logic tmr_expire;
	logic edge_pulse;
	logic [1:0] irq_en;

	assign aw_take = s_axi_awvalid_i && awready_ff;
	assign w_take = s_axi_wvalid_i && wready_ff;
	assign ar_take = s_axi_arvalid_i && arready_ff;
	assign do_wr = aw_held_ff && w_held_ff && !bvalid_ff;
	assign wr_sel = rit_decode(awaddr_ff);
	assign rd_sel = rit_decode(s_axi_araddr_i);
	// Low byte lane carries the 8-bit data; others ignored
	assign wr_en = do_wr && wstrb0_ff;
	assign wr_idx = awaddr_ff[5:2];
	assign rd_idx = s_axi_araddr_i[5:2];
	assign wr_ram_idx = awaddr_ff[RAM_AW+1:2];
	assign rd_ram_idx = s_axi_araddr_i[RAM_AW+1:2];
	assign rd_irq_line = rd_idx[IDX_IRQ_EN_BIT];
	assign wr_tmr = wr_en && wr_sel == SEL_TMR;
	assign rd_tmr = ar_take && rd_sel == SEL_TMR && !rd_idx[IDX_FLAG_BIT];
	assign rd_flag = ar_take && rd_sel == SEL_TMR && rd_idx[IDX_FLAG_BIT];
	assign port_a_top_pin = port_a_i[7];
	// Port B reads the latch on output bits, immune to pin loading
	assign port_b_view = (port_b_direction_ff & port_b_output_latch_ff) |
		(~port_b_direction_ff & port_b_i);
	assign irq_en = {edge_ctl_ff[EDGE_EN_BIT], timer_irq_enable_line_ff};

	// Write channels: address and data taken in either order
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			awready_ff <= 1'b0;
			aw_held_ff <= 1'b0;
			awaddr_ff <= 12'h000;
			wready_ff <= 1'b0;
			w_held_ff <= 1'b0;
			wdata_ff <= 8'h00;
			wstrb0_ff <= 1'b0;
		end else begin
			if (aw_take) begin
				awready_ff <= 1'b0;
				aw_held_ff <= 1'b1;
				awaddr_ff <= s_axi_awaddr_i;
			end else if (do_wr) begin
				aw_held_ff <= 1'b0;
			end else if (!aw_held_ff && !bvalid_ff) begin
				awready_ff <= 1'b1;
			end
			if (w_take) begin
				wready_ff <= 1'b0;
				w_held_ff <= 1'b1;
				wdata_ff <= s_axi_wdata_i[7:0];
				wstrb0_ff <= s_axi_wstrb_i[0];
			end else if (do_wr) begin
				w_held_ff <= 1'b0;
			end else if (!w_held_ff && !bvalid_ff) begin
				wready_ff <= 1'b1;
			end
		end
	end

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			bvalid_ff <= 1'b0;
			bresp_ff <= RESP_OKAY;
		end else if (do_wr) begin
			bvalid_ff <= 1'b1;
			bresp_ff <= (wr_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
		end else if (s_axi_bready_i) begin
			bvalid_ff <= 1'b0;
		end
	end

	always_comb begin
		nxt_rdata = 8'h00;
		nxt_rresp = RESP_OKAY;
		unique case (rd_sel)
			SEL_RAM: nxt_rdata = ram_mem[rd_ram_idx];
			SEL_PORT: begin
				unique case (rd_idx[1:0])
					PORT_PA_DATA: nxt_rdata = port_a_i;
					PORT_PA_DIR: nxt_rdata = port_a_direction_ff;
					PORT_PB_DATA: nxt_rdata = port_b_view;
					PORT_PB_DIR: nxt_rdata = port_b_direction_ff;
				endcase
			end
			SEL_TMR: begin
				if (rd_idx[IDX_FLAG_BIT]) begin
					nxt_rdata[FLAG_TMR_BIT] = tmr_flag;
					nxt_rdata[FLAG_EDGE_BIT] = edge_flag_ff;
				end else begin
					nxt_rdata = tmr_count;
				end
			end
			SEL_OWN: begin
				if (s_axi_araddr_i == STS_ADDR) begin
					nxt_rdata = {6'h00, sts_ff};
				end else if (s_axi_araddr_i == MSK_ADDR) begin
					nxt_rdata = {6'h00, msk_ff};
				end else begin
					nxt_rdata = {6'h00, edge_ctl_ff};
				end
			end
			SEL_NONE: nxt_rresp = RESP_SLVERR;
		endcase
	end

	// Read data stays zero and invalid while in reset
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			arready_ff <= 1'b0;
			rvalid_ff <= 1'b0;
			rresp_ff <= RESP_OKAY;
			rdata_ff <= 8'h00;
		end else if (ar_take) begin
			arready_ff <= 1'b0;
			rvalid_ff <= 1'b1;
			rresp_ff <= nxt_rresp;
			rdata_ff <= nxt_rdata;
		end else if (rvalid_ff) begin
			if (s_axi_rready_i) begin
				rvalid_ff <= 1'b0;
			end
		end else begin
			arready_ff <= 1'b1;
		end
	end

	// Memory keeps its contents across reset
	always_ff @(posedge sys_clk_i) begin
		if (wr_en && wr_sel == SEL_RAM) begin
			ram_mem[wr_ram_idx] <= wdata_ff;
		end
	end

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			port_a_direction_ff <= PORT_RST;
			port_b_direction_ff <= PORT_RST;
			port_a_output_latch_ff <= PORT_RST;
			port_b_output_latch_ff <= PORT_RST;
		end else if (wr_en && wr_sel == SEL_PORT) begin
			unique case (wr_idx[1:0])
				PORT_PA_DATA: port_a_output_latch_ff <= wdata_ff;
				PORT_PA_DIR: port_a_direction_ff <= wdata_ff;
				PORT_PB_DATA: port_b_output_latch_ff <= wdata_ff;
				PORT_PB_DIR: port_b_direction_ff <= wdata_ff;
			endcase
		end
	end

	rit_timer u_timer (
		.sys_clk_i(sys_clk_i),
		.rst_i(rst_i),
		.load_i(wr_tmr),
		.load_val_i(wdata_ff),
		.pre_sel_i(wr_idx[1:0]),
		.access_i(wr_tmr || rd_tmr),
		.count_o(tmr_count),
		.flag_o(tmr_flag),
		.expire_o(tmr_expire)
	);

	rit_edge u_edge (
		.sys_clk_i(sys_clk_i),
		.rst_i(rst_i),
		.pin_i(port_a_top_pin),
		.rising_i(edge_ctl_ff[EDGE_RISE_BIT]),
		.edge_o(edge_pulse)
	);

	// A write wins over a read in the same cycle
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			timer_irq_enable_line_ff <= 1'b0;
		end else if (wr_tmr) begin
			timer_irq_enable_line_ff <= wr_idx[IDX_IRQ_EN_BIT];
		end else if (rd_tmr) begin
			timer_irq_enable_line_ff <= rd_irq_line;
		end
	end

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			edge_ctl_ff <= IRQ_RST;
			msk_ff <= IRQ_RST;
		end else if (wr_en && wr_sel == SEL_OWN) begin
			if (awaddr_ff == MSK_ADDR) begin
				msk_ff <= wdata_ff[1:0];
			end else if (awaddr_ff == EDGE_ADDR) begin
				edge_ctl_ff <= wdata_ff[1:0];
			end
		end
	end

	// Hardware set beats software clear in the same cycle
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			sts_ff <= IRQ_RST;
			edge_flag_ff <= 1'b0;
			irq_ff <= 1'b0;
		end else begin
			if (wr_en && awaddr_ff == STS_ADDR) begin
				sts_ff <= (sts_ff & ~wdata_ff[1:0]) | {edge_pulse, tmr_expire};
			end else begin
				sts_ff <= sts_ff | {edge_pulse, tmr_expire};
			end
			if (edge_pulse) begin
				edge_flag_ff <= 1'b1;
			end else if (rd_flag) begin
				edge_flag_ff <= 1'b0;
			end
			irq_ff <= |(sts_ff & msk_ff & irq_en);
		end
	end

	assign s_axi_awready_o = awready_ff;
	assign s_axi_wready_o = wready_ff;
	assign s_axi_bvalid_o = bvalid_ff;
	assign s_axi_bresp_o = bresp_ff;
	assign s_axi_arready_o = arready_ff;
	assign s_axi_rvalid_o = rvalid_ff;
	assign s_axi_rresp_o = rresp_ff;
	assign s_axi_rdata_o = {24'h000000, rdata_ff};
	assign port_a_o = port_a_output_latch_ff;
	assign port_a_oe_o = port_a_direction_ff;
	assign port_b_o = port_b_output_latch_ff;
	assign port_b_oe_o = port_b_direction_ff;
	assign irq_o = irq_ff;

	rst_clear_a: assert property (@(posedge sys_clk_i)
		$fell(rst_i) |-> (port_a_oe_o == 8'h00 && port_b_oe_o == 8'h00 &&
		port_a_o == 8'h00 && port_b_o == 8'h00))
		else $error("ports not cleared by reset");

	bus_idle_a: assert property (@(posedge sys_clk_i)
		$fell(rst_i) |-> (!rvalid_ff && rdata_ff == 8'h00 && !bvalid_ff))
		else $error("bus answer driven during reset");

	irq_quiet_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		(irq_en == 2'h0) |=> !irq_ff)
		else $error("interrupt raised while disabled");

	ram_store_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		(wr_en && wr_sel == SEL_RAM) |=>
		ram_mem[$past(wr_ram_idx)] == $past(wdata_ff))
		else $error("memory byte not stored");

	dir_write_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		(wr_en && wr_sel == SEL_PORT && wr_idx[1:0] == PORT_PA_DIR) |=>
		port_a_oe_o == $past(wdata_ff))
		else $error("direction write not applied");

	pb_read_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		(ar_take && rd_sel == SEL_PORT && rd_idx[1:0] == PORT_PB_DATA) |=>
		(rvalid_ff && rdata_ff == $past(port_b_view)))
		else $error("port b read wrong");

	tmr_enable_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		(rd_tmr && !wr_tmr) |=> timer_irq_enable_line_ff == $past(rd_irq_line))
		else $error("timer enable not sampled on read");

	edge_status_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		edge_pulse |=> (sts_ff[STS_EDGE] && edge_flag_ff) ##1
		(irq_ff == (msk_ff[STS_EDGE] && $past(irq_en[STS_EDGE]))))
		else $error("edge event lost");

endmodule

/* testbench/rit_pin_model.sv */
// Peripheral device model on the port pins, with pull-ups
`timescale 1ns/10ps
module rit_pin_model (
	input wire logic [7:0] dev_out_i,
	input wire logic [7:0] dev_oe_i,
	input wire logic [7:0] ext_val_i,
	input wire logic [7:0] ext_en_i,
	output logic [7:0] pin_o
);
	// A released pin with ext_en_i low floats up, so stale levels never linger
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			if (dev_oe_i[i]) begin
				pin_o[i] = dev_out_i[i];
			end else begin
				pin_o[i] = ext_en_i[i] ? ext_val_i[i] : 1'b1;
			end
		end
	end
endmodule

/* testbench/tb_ram_io_timer_peripheral.sv */
// Self-checking bench for the RAM, port, timer and edge block
`timescale 1ns/10ps
module tb_ram_io_timer_peripheral;
	import rit_pkg::*;
	logic clk, rst, awvalid, wvalid, bready, arvalid, rready;
	logic awready, wready, bvalid, arready, rvalid, irq;
	logic [11:0] awaddr, araddr;
	logic [31:0] wdata, rdata, d;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, r;
	logic [7:0] pa_pin, pa_out, pa_oe, pa_ext, pb_pin, pb_out, pb_oe, pb_ext;
	int failures, compares, n;
	int divs[4] = '{1, 8, 64, 1024};
	logic [11:0] ram_a[4] = '{12'h000, 12'h004, 12'h0fc, 12'h1fc};

	rit_top DUT (.sys_clk_i(clk), .rst_i(rst), .s_axi_awaddr_i(awaddr),
		.s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
		.s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb),
		.s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
		.s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
		.s_axi_bready_i(bready), .s_axi_araddr_i(araddr),
		.s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
		.s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
		.s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
		.port_a_i(pa_pin), .port_a_o(pa_out), .port_a_oe_o(pa_oe),
		.port_b_i(pb_pin), .port_b_o(pb_out), .port_b_oe_o(pb_oe),
		.irq_o(irq));
	rit_pin_model pa_model (.dev_out_i(pa_out), .dev_oe_i(pa_oe),
		.ext_val_i(pa_ext), .ext_en_i(8'hff), .pin_o(pa_pin));
	rit_pin_model pb_model (.dev_out_i(pb_out), .dev_oe_i(pb_oe),
		.ext_val_i(pb_ext), .ext_en_i(8'hff), .pin_o(pb_pin));

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	task automatic chk(input string what, input logic [31:0] exp,
			input logic [31:0] got);
		compares++;
		if (got !== exp) begin
			failures++;
			$display("wrong value %s: expected %h, seen %h", what, exp, got);
		end
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] v,
			output logic [1:0] resp);
		logic aw_ok;
		logic w_ok;
		aw_ok = 1'b0;
		w_ok = 1'b0;
		@(posedge clk);
		awaddr <= a;
		awvalid <= 1'b1;
		wdata <= v;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!(aw_ok && w_ok)) begin
			@(posedge clk);
			if (!aw_ok && awready === 1'b1) begin
				aw_ok = 1'b1;
				awvalid <= 1'b0;
			end
			if (!w_ok && wready === 1'b1) begin
				w_ok = 1'b1;
				wvalid <= 1'b0;
			end
		end
		do @(posedge clk); while (bvalid !== 1'b1);
		resp = bresp;
		bready <= 1'b0;
	endtask

	task automatic rd(input logic [11:0] a, output logic [31:0] v,
			output logic [1:0] resp);
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge clk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge clk); while (rvalid !== 1'b1);
		v = rdata;
		resp = rresp;
		rready <= 1'b0;
	endtask

	task automatic wrc(input logic [11:0] a, input logic [31:0] v);
		logic [1:0] rsp;
		wr(a, v, rsp);
		chk("bresp", 32'(RESP_OKAY), 32'(rsp));
	endtask

	task automatic rdc(input string w, input logic [11:0] a,
			input logic [31:0] exp);
		logic [31:0] v;
		logic [1:0] rsp;
		rd(a, v, rsp);
		chk(w, exp, v);
		chk("rresp", 32'(RESP_OKAY), 32'(rsp));
	endtask

	task automatic do_reset;
		@(posedge clk);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		chk("ports", 32'h0, {pa_out, pb_out, pa_oe, pb_oe});
		chk("rdata", 32'h0, rdata);
		chk("rvalid", 32'h0, 32'(rvalid));
		chk("irq", 32'h0, 32'(irq));
		@(posedge clk);
		rst <= 1'b0;
		$display("test reset done");
	endtask

	task automatic test_done;
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	initial begin
		rst = 1'b1;
		{awaddr, araddr, wdata} = '0;
		{awvalid, wvalid, bready, arvalid, rready} = '0;
		wstrb = 4'h1;
		pa_ext = 8'h3c;
		pb_ext = 8'hc3;
		failures = 0;
		compares = 0;
		do_reset;
		// Upper garbage in wdata must never come back
		foreach (ram_a[i]) wrc(ram_a[i], 32'hdeadbe00 | 32'(8'h11 * (i + 1)));
		foreach (ram_a[i]) rdc("ram", ram_a[i], 32'(8'h11 * (i + 1)));
		// Low lane strobe off: the byte must stay untouched
		wstrb <= 4'h0;
		wrc(ram_a[0], 32'h99);
		wstrb <= 4'h1;
		rdc("gated byte", ram_a[0], 32'h11);
		$display("test ram done");
		wrc(12'h204, 32'hf0);
		wrc(12'h200, 32'ha5);
		wrc(12'h20c, 32'h0f);
		wrc(12'h208, 32'h5a);
		chk("port a pins", 32'hf0a5, {pa_oe, pa_out});
		chk("port b pins", 32'h0f5a, {pb_oe, pb_out});
		repeat (3) @(posedge clk);
		rdc("port a read", 12'h200, 32'hac);
		rdc("port a dir", 12'h204, 32'hf0);
		rdc("port b read", 12'h208, 32'hca);
		rdc("port b dir", 12'h20c, 32'h0f);
		$display("test ports done");
		do_reset;
		rdc("dir after reset", 12'h204, 32'h0);
		wrc(MSK_ADDR, 32'h3);
		// Zero load expires after one clock; one count at /8 after nine
		wrc(12'h210, 32'h0);
		repeat (3) @(posedge clk);
		rdc("one clock timeout", STS_ADDR, 32'h1);
		wrc(STS_ADDR, 32'h1);
		wrc(12'h214, 32'h1);
		rdc("eight not yet", STS_ADDR, 32'h0);
		repeat (8) @(posedge clk);
		rdc("eight expired", STS_ADDR, 32'h1);
		wrc(STS_ADDR, 32'h1);
		for (int s = 0; s < 4; s++) begin
			wrc(12'h230 | 12'(s << 2), 32'h2);
			if (s == 3) rdc("count", 12'h238, 32'h2);
			n = 0;
			while (irq !== 1'b1 && n < 4000) begin
				@(posedge clk);
				n++;
			end
			chk("expiry time", 32'h1, 32'(n >= 2 * divs[s] - 6 &&
				n <= 2 * divs[s] + 5));
			rdc("timer flag", 12'h214, 32'h80);
			rd(12'h210, d, r);
			repeat (3) @(posedge clk);
			chk("irq after read", 32'h0, 32'(irq));
			rdc("flag cleared", 12'h214, 32'h0);
			rdc("status", STS_ADDR, 32'h1);
			wrc(STS_ADDR, 32'h1);
		end
		$display("test timer done");
		wrc(MSK_ADDR, 32'h2);
		for (int p = 1; p >= 0; p--) begin
			wrc(EDGE_ADDR, 32'h2 | 32'(p));
			pa_ext <= {p[0], 7'h3c};
			repeat (5) @(posedge clk);
			chk("edge irq", 32'h1, 32'(irq));
			rdc("edge flag", 12'h214, 32'h40);
			wrc(STS_ADDR, 32'h2);
			rdc("edge status", STS_ADDR, 32'h0);
			chk("edge irq off", 32'h0, 32'(irq));
		end
		// Masked edge still latches; opposite edge must not
		wrc(EDGE_ADDR, 32'h3);
		wrc(MSK_ADDR, 32'h0);
		pa_ext <= 8'hbc;
		repeat (5) @(posedge clk);
		chk("masked irq", 32'h0, 32'(irq));
		rdc("masked status", STS_ADDR, 32'h2);
		wrc(STS_ADDR, 32'h2);
		pa_ext <= 8'h3c;
		repeat (5) @(posedge clk);
		rdc("wrong edge", STS_ADDR, 32'h0);
		$display("test edge done");
		wr(12'h400, 32'h55, r);
		chk("bad bresp", 32'(RESP_SLVERR), 32'(r));
		rd(12'h400, d, r);
		chk("bad rresp", 32'(RESP_SLVERR), 32'(r));
		chk("bad rdata", 32'h0, d);
		$display("test unmapped done");
		test_done;
	end

	initial begin
		repeat (20000) @(posedge clk);
		failures++;
		test_done;
	end
endmodule
